// File: core/nvsram_host.sv
// host controller driving a nonvolatile sram over its async pins
`timescale 1ns/1ps
// How it works
// - write enable stays high during reads
// - six command reads issued in fixed order
// - write enable high across all six steps
// - steps strobed by select or output enable
// - no other access inside a sequence
module nvsram_host #(
    parameter int STORE_CYCLES = nvsram_host_pkg::STORE_CYC,
    parameter int RECALL_CYCLES = nvsram_host_pkg::RECALL_CYC,
    parameter int RESTORE_CYCLES = nvsram_host_pkg::RESTORE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_req_valid,
    input wire logic [1:0] i_req_op,
    input wire logic [nvsram_host_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [nvsram_host_pkg::DATA_W-1:0] i_req_wdata,
    input wire logic [1:0] i_req_cmd,
    input wire logic i_use_oe_strobe,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [nvsram_host_pkg::DATA_W-1:0] o_rsp_rdata,
    output logic o_busy,
    output logic [nvsram_host_pkg::ADDR_W-1:0] o_addr,
    output logic o_ce_b,
    output logic o_we_b,
    output logic o_oe_b,
    output logic [nvsram_host_pkg::DATA_W-1:0] o_data_pins,
    output logic o_data_pins_oe,
    input wire logic [nvsram_host_pkg::DATA_W-1:0] i_data_pins
);
    // the phase timer is 24 bits wide and cannot time a zero wait
    if (STORE_CYCLES < 1 || RECALL_CYCLES < 1 || RESTORE_CYCLES < 1 ||
        STORE_CYCLES > 24'hffffff || RECALL_CYCLES > 24'hffffff ||
        RESTORE_CYCLES > 24'hffffff) begin : g_bad_counts
        $error("busy counts out of range");
    end

    typedef enum logic [2:0] {
        ST_POWERUP, ST_IDLE, ST_SETUP, ST_STROBE, ST_RELEASE, ST_BUSY
    } state_type;

    typedef struct packed {
        state_type st;
        logic [nvsram_host_pkg::ADDR_W-1:0] addr;
        logic [nvsram_host_pkg::DATA_W-1:0] wdata;
        logic [nvsram_host_pkg::DATA_W-1:0] rdata;
        logic [1:0] op;
        logic [1:0] cmd;
        logic [2:0] step;
        logic oe_mode;
        logic ce_b;
        logic we_b;
        logic oe_b;
        logic drive;
        logic rsp;
        logic start;
    } host_type;

    host_type s_r, s_nxt;
    nvsram_strobe_if tif ();

    nvsram_wait_timer nvsram_wait_timer_i (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .tif(tif)
    );

    // sequence address for a step; sixth step is the command code
    function automatic logic [15:0] seq_addr(input logic [2:0] step, input logic [1:0] cmd);
        case (step)
            3'h0: seq_addr = nvsram_host_pkg::SEQ_0;
            3'h1: seq_addr = nvsram_host_pkg::SEQ_1;
            3'h2: seq_addr = nvsram_host_pkg::SEQ_2;
            3'h3: seq_addr = nvsram_host_pkg::SEQ_3;
            3'h4: seq_addr = nvsram_host_pkg::SEQ_4;
            default: begin
                case (cmd)
                    nvsram_host_pkg::NV_STORE: seq_addr = nvsram_host_pkg::CMD_STORE;
                    nvsram_host_pkg::NV_RECALL: seq_addr = nvsram_host_pkg::CMD_RECALL;
                    nvsram_host_pkg::NV_INHIBIT: seq_addr = nvsram_host_pkg::CMD_INHIBIT;
                    default: seq_addr = nvsram_host_pkg::CMD_RELEASE;
                endcase
            end
        endcase
    endfunction

    function automatic logic [23:0] busy_cycles(input logic [1:0] cmd);
        case (cmd)
            nvsram_host_pkg::NV_STORE: busy_cycles = 24'(STORE_CYCLES);
            nvsram_host_pkg::NV_RECALL: busy_cycles = 24'(RECALL_CYCLES);
            default: busy_cycles = 24'h0;
        endcase
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp = 1'b0;
        s_nxt.start = 1'b0;
        tif.load = 1'b0;
        tif.count = 24'h0;
        case (s_r.st)
            ST_POWERUP: begin
                // wait out the power-up recall before the first access
                if (s_r.start) begin
                    tif.load = 1'b1;
                    tif.count = 24'(RESTORE_CYCLES);
                end else if (tif.done) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (i_req_valid) begin
                    s_nxt.op = i_req_op;
                    s_nxt.cmd = i_req_cmd;
                    s_nxt.wdata = i_req_wdata;
                    s_nxt.step = 3'h0;
                    s_nxt.oe_mode = i_use_oe_strobe;
                    if (i_req_op == nvsram_host_pkg::OP_CMD) begin
                        // top address bit left low; device ignores it
                        s_nxt.addr = {1'b0, seq_addr(3'h0, i_req_cmd)};
                    end else begin
                        s_nxt.addr = i_req_addr;
                    end
                    s_nxt.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // address settled first; strobe only after setup
                s_nxt.we_b = 1'b1;
                s_nxt.drive = 1'b0;
                if (s_r.op == nvsram_host_pkg::OP_WRITE) begin
                    s_nxt.ce_b = 1'b0;
                    s_nxt.oe_b = 1'b1;
                    s_nxt.st = ST_STROBE;
                end else if (s_r.op == nvsram_host_pkg::OP_CMD && s_r.oe_mode) begin
                    s_nxt.ce_b = 1'b0;
                    s_nxt.oe_b = 1'b1;
                    s_nxt.st = ST_STROBE;
                end else begin
                    s_nxt.ce_b = 1'b0;
                    s_nxt.oe_b = 1'b0;
                    s_nxt.st = ST_STROBE;
                end
                tif.load = 1'b1;
                tif.count = 24'(nvsram_host_pkg::PHASE_CYC);
            end
            ST_STROBE: begin
                if (s_r.op == nvsram_host_pkg::OP_WRITE) begin
                    s_nxt.we_b = 1'b0;
                    s_nxt.drive = 1'b1;
                end else begin
                    s_nxt.oe_b = 1'b0;
                end
                if (tif.done) begin
                    tif.load = 1'b1;
                    tif.count = 24'(nvsram_host_pkg::STROBE_CYC);
                    s_nxt.st = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (tif.done) begin
                    if (s_r.op == nvsram_host_pkg::OP_READ) begin
                        s_nxt.rdata = i_data_pins;
                        s_nxt.rsp = 1'b1;
                    end
                    s_nxt.we_b = 1'b1;
                    s_nxt.oe_b = 1'b1;
                    s_nxt.drive = 1'b0;
                    // select-strobed steps end on select, others on output enable
                    s_nxt.ce_b = s_r.op == nvsram_host_pkg::OP_CMD && s_r.oe_mode ? 1'b0 : 1'b1;
                    if (s_r.op == nvsram_host_pkg::OP_CMD &&
                        s_r.step != 3'(nvsram_host_pkg::SEQ_LEN - 1)) begin
                        // next step follows directly, no other access between
                        s_nxt.step = s_r.step + 3'h1;
                        s_nxt.addr = {1'b0, seq_addr(s_r.step + 3'h1, s_r.cmd)};
                        s_nxt.st = ST_SETUP;
                    end else if (s_r.op == nvsram_host_pkg::OP_CMD) begin
                        s_nxt.ce_b = 1'b1;
                        s_nxt.start = 1'b1;
                        s_nxt.st = ST_BUSY;
                    end else begin
                        s_nxt.st = ST_IDLE;
                    end
                end
            end
            ST_BUSY: begin
                // no access until the nonvolatile cycle ends
                if (s_r.start) begin
                    tif.load = busy_cycles(s_r.cmd) != 24'h0;
                    tif.count = busy_cycles(s_r.cmd);
                    if (busy_cycles(s_r.cmd) == 24'h0) begin
                        s_nxt.rsp = 1'b1;
                        s_nxt.st = ST_IDLE;
                    end
                end else if (tif.done) begin
                    s_nxt.rsp = 1'b1;
                    s_nxt.st = ST_IDLE;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_r <= '0;
            s_r.st <= ST_POWERUP;
            s_r.ce_b <= 1'b1;
            s_r.we_b <= 1'b1;
            s_r.oe_b <= 1'b1;
            s_r.start <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_req_ready = s_r.st == ST_IDLE;
    assign o_rsp_valid = s_r.rsp;
    assign o_rsp_rdata = s_r.rdata;
    assign o_busy = s_r.st != ST_IDLE;
    assign o_addr = s_r.addr;
    assign o_ce_b = s_r.ce_b;
    assign o_we_b = s_r.we_b;
    assign o_oe_b = s_r.oe_b;
    assign o_data_pins = s_r.wdata;
    assign o_data_pins_oe = s_r.drive;
endmodule

// File: core/nvsram_host_pkg.sv
// constants for the nonvolatile sram host controller
package nvsram_host_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int SEQ_LEN = 6;
    localparam int MATCH_W = 16;
    localparam logic [15:0] SEQ_0 = 16'h4e38;
    localparam logic [15:0] SEQ_1 = 16'hb1c7;
    localparam logic [15:0] SEQ_2 = 16'h83e0;
    localparam logic [15:0] SEQ_3 = 16'h7c1f;
    localparam logic [15:0] SEQ_4 = 16'h703f;
    localparam logic [15:0] CMD_STORE = 16'h8fc0;
    localparam logic [15:0] CMD_RECALL = 16'h4c63;
    localparam logic [15:0] CMD_INHIBIT = 16'h8b45;
    localparam logic [15:0] CMD_RELEASE = 16'h4b46;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_CMD = 2'h2;
    localparam logic [1:0] NV_STORE = 2'h0;
    localparam logic [1:0] NV_RECALL = 2'h1;
    localparam logic [1:0] NV_INHIBIT = 2'h2;
    localparam logic [1:0] NV_RELEASE = 2'h3;
    localparam int CLK_HZ = 10_000_000;
    // times in their own units
    localparam int T_STORE_MS = 10;
    localparam int T_RECALL_US = 20;
    localparam int T_RESTORE_MS = 5;
    localparam int STORE_CYC = T_STORE_MS * (CLK_HZ / 1000);
    localparam int RECALL_CYC = T_RECALL_US * (CLK_HZ / 1_000_000);
    localparam int RESTORE_CYC = T_RESTORE_MS * (CLK_HZ / 1000);
    // one bus access phase length in clocks (100 ns each)
    localparam logic [3:0] PHASE_CYC = 4'h1;
    localparam logic [3:0] STROBE_CYC = 4'h2;
endpackage

// File: core/nvsram_strobe_if.sv
// strobe-timer link between the sequencer and its phase timer
`timescale 1ns/1ps
interface nvsram_strobe_if;
    logic load;
    logic [23:0] count;
    logic done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

// File: core/nvsram_wait_timer.sv
// down counter that times strobe phases and busy periods
`timescale 1ns/1ps
module nvsram_wait_timer (
    input wire logic i_clk,
    input wire logic i_rst_b,
    nvsram_strobe_if.tmr tif
);
    typedef struct packed {
        logic [23:0] cnt;
        logic run;
    } st_type;
    st_type s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        if (tif.load) begin
            s_nxt.cnt = tif.count;
            s_nxt.run = 1'b1;
        end else if (s_r.run && s_r.cnt != 24'h0) begin
            s_nxt.cnt = s_r.cnt - 24'h1;
        end else begin
            s_nxt.run = 1'b0;
        end
    end
    // done must not depend on load: the sequencer reloads in answer to done
    assign tif.done = s_r.run && (s_r.cnt == 24'h0);
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// File: tb/nvsram_dev_model.sv
// behavioural nonvolatile sram seen from its pins
`timescale 1ns/1ps
module nvsram_dev_model (
    input wire logic i_clk,
    input wire logic [16:0] i_addr,
    input wire logic i_ce_b,
    input wire logic i_we_b,
    input wire logic i_oe_b,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic [7:0] o_events = 8'h00,
    output logic [1:0] o_last = 2'h0,
    output logic o_inhibit = 1'b0,
    output logic o_dirty = 1'b0
);
    logic [7:0] mem [131072];
    logic [15:0] lead [5];
    logic [16:0] a_p = 17'h00000;
    logic [7:0] last_q = 8'h00;
    logic rd_p = 1'b0;
    logic rd;
    logic nv_hit;
    int step = 0;
    initial begin
        lead = '{nvsram_host_pkg::SEQ_0, nvsram_host_pkg::SEQ_1, nvsram_host_pkg::SEQ_2,
            nvsram_host_pkg::SEQ_3, nvsram_host_pkg::SEQ_4};
    end
    assign rd = !i_ce_b && !i_oe_b && i_we_b;
    assign nv_hit = step == 5 && (i_addr[15:0] == nvsram_host_pkg::CMD_STORE
        || i_addr[15:0] == nvsram_host_pkg::CMD_RECALL);
    // a released bus shows the inverse of the last byte, never a stale match
    assign o_data = (rd && !nv_hit) ? mem[i_addr] : ~last_q;
    // inhibit survives everything but a release command: the model has no power cycle
    task automatic hit(input logic [1:0] code);
        o_events <= o_events + 8'h01;
        o_last <= code;
        if (code < 2'h2) o_dirty <= 1'b0;
        if (code[1]) o_inhibit <= !code[0];
    endtask
    always @(posedge i_clk) begin
        if (!i_ce_b && !i_we_b) begin
            mem[i_addr] <= i_data;
            step <= 0;
            o_dirty <= 1'b1;
        end
        if (rd) last_q <= o_data;
        if (rd) a_p <= i_addr;
        rd_p <= rd;
        if (rd_p && !rd && i_we_b) begin
            if (step == 5) begin
                step <= 0;
                case (a_p[15:0])
                    nvsram_host_pkg::CMD_STORE: hit(2'h0);
                    nvsram_host_pkg::CMD_RECALL: hit(2'h1);
                    nvsram_host_pkg::CMD_INHIBIT: hit(2'h2);
                    nvsram_host_pkg::CMD_RELEASE: hit(2'h3);
                    default: ;
                endcase
            end else if (a_p[15:0] == lead[step]) step <= step + 1;
            else step <= (a_p[15:0] == lead[0]) ? 1 : 0;
        end
    end
endmodule

// File: tb/nvsram_host_bench.sv
// self-checking bench for the nonvolatile sram host controller
`timescale 1ns/1ps
module nvsram_host_bench;
    localparam int NV_CYC = 20;
    logic i_clk = 1'b0;
    logic i_rst_b, i_req_valid, i_use_oe_strobe, o_req_ready, o_rsp_valid, o_busy;
    logic o_ce_b, o_we_b, o_oe_b, o_data_pins_oe, dev_inhibit, dev_dirty;
    logic [1:0] i_req_op, i_req_cmd, dev_last;
    logic [16:0] i_req_addr, o_addr;
    logic [7:0] i_req_wdata, o_rsp_rdata, o_data_pins, dev_data, dev_events;
    int mismatches = 0;
    int comparisons = 0;
    nvsram_host #(.STORE_CYCLES(NV_CYC), .RECALL_CYCLES(NV_CYC), .RESTORE_CYCLES(NV_CYC))
    nvsram_host_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
        .i_req_op(i_req_op), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
        .i_req_cmd(i_req_cmd), .i_use_oe_strobe(i_use_oe_strobe), .o_req_ready(o_req_ready),
        .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .o_busy(o_busy),
        .o_addr(o_addr), .o_ce_b(o_ce_b), .o_we_b(o_we_b), .o_oe_b(o_oe_b),
        .o_data_pins(o_data_pins), .o_data_pins_oe(o_data_pins_oe), .i_data_pins(dev_data));
    nvsram_dev_model nvsram_dev_model_i (.i_clk(i_clk), .i_addr(o_addr), .i_ce_b(o_ce_b),
        .i_we_b(o_we_b), .i_oe_b(o_oe_b), .i_data(o_data_pins), .o_data(dev_data),
        .o_events(dev_events), .o_last(dev_last), .o_inhibit(dev_inhibit), .o_dirty(dev_dirty));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bail(input int n);
        if (n > 600) begin
            mismatches++;
            $display("[ERR] %0t wait ran out", $time);
            give_verdict();
        end
    endtask
    // one whole request: wait ready, present for one edge, wait the answer
    task automatic req(input logic [1:0] op, input logic [16:0] a, input logic [7:0] d,
        input logic [1:0] c, output logic [7:0] q, output int cyc);
        int n;
        n = 0;
        @(posedge i_clk);
        while (o_req_ready !== 1'b1) begin
            n++;
            bail(n);
            @(posedge i_clk);
        end
        i_req_valid <= 1'b1;
        i_req_op <= op;
        i_req_addr <= a;
        i_req_wdata <= d;
        i_req_cmd <= c;
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        cyc = 0;
        // writes give no answer pulse: their end is ready coming back
        do begin
            @(posedge i_clk);
            cyc++;
            bail(cyc);
        end while (op == nvsram_host_pkg::OP_WRITE ? o_req_ready !== 1'b1
            : o_rsp_valid !== 1'b1);
        q = o_rsp_rdata;
    endtask
    // reset in mid-run: no access until the power-up recall wait is over
    task automatic t_restore();
        int n;
        n = 0;
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        check(o_busy, 32'h1);
        while (o_req_ready !== 1'b1) begin
            n++;
            bail(n);
            @(posedge i_clk);
        end
        check(n >= NV_CYC, 32'h1);
    endtask
    // same low half, different top bit: both bytes must stay apart
    task automatic t_rw();
        logic [7:0] q;
        int c;
        req(nvsram_host_pkg::OP_WRITE, 17'h14e38, 8'h5a, 2'h0, q, c);
        req(nvsram_host_pkg::OP_WRITE, 17'h04e38, 8'ha5, 2'h0, q, c);
        check(dev_dirty, 32'h1);
        req(nvsram_host_pkg::OP_READ, 17'h14e38, 8'h00, 2'h0, q, c);
        check(q, 32'h5a);
        req(nvsram_host_pkg::OP_READ, 17'h04e38, 8'h00, 2'h0, q, c);
        check(q, 32'ha5);
    endtask
    task automatic t_cmds();
        logic [7:0] q;
        logic [7:0] ev;
        int c;
        int cs [4];
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 4; k++) begin
                ev = dev_events;
                i_use_oe_strobe <= s[0];
                req(nvsram_host_pkg::OP_CMD, 17'h00000, 8'h00, k[1:0], q, c);
                check(dev_events, ev + 8'h01);
                check(dev_last, k);
                check(dev_inhibit, k == 2);
                cs[k] = c;
                if (k < 2) check(dev_dirty, 32'h0);
            end
            // the six steps cost the same for every code; the rest is the busy wait
            check(cs[0] - cs[2] >= NV_CYC, 32'h1);
            check(cs[1] - cs[2] >= NV_CYC, 32'h1);
            check(cs[3], cs[2]);
        end
    endtask
    initial begin
        i_rst_b = 1'b0;
        i_req_valid = 1'b0;
        i_req_op = 2'h0;
        i_req_addr = 17'h00000;
        i_req_wdata = 8'h00;
        i_req_cmd = 2'h0;
        i_use_oe_strobe = 1'b0;
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_rw();
        t_cmds();
        t_restore();
        t_rw();
        give_verdict();
    end
endmodule

// File: tb/nvsram_host_checker.sv
// pin-level assertions for the nonvolatile sram host controller
`timescale 1ns/1ps
module nvsram_host_checker (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_req_valid,
    input wire logic [1:0] i_req_op,
    input wire logic o_req_ready,
    input wire logic o_rsp_valid,
    input wire logic o_busy,
    input wire logic [nvsram_host_pkg::ADDR_W-1:0] o_addr,
    input wire logic o_ce_b,
    input wire logic o_we_b,
    input wire logic o_oe_b,
    input wire logic o_data_pins_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic cmd_r;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) cmd_r <= 1'b0;
        else if (i_req_valid && o_req_ready) cmd_r <= i_req_op == nvsram_host_pkg::OP_CMD;
        else if (o_rsp_valid) cmd_r <= 1'b0;
    end
    sequence s_take(logic [1:0] op);
        i_req_valid && o_req_ready && i_req_op == op;
    endsequence
    property p_read_answer; s_take(nvsram_host_pkg::OP_READ) |-> ##[2:12] o_rsp_valid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_read_we; !o_oe_b |-> o_we_b; endproperty
    a_read_we: assert property (p_read_we) else $error("write enable low in read");
    property p_ce_fall; $fell(o_ce_b) |-> o_we_b; endproperty
    a_ce_fall: assert property (p_ce_fall) else $error("write enable low at select");
    property p_cmd_we; cmd_r |-> o_we_b; endproperty
    a_cmd_we: assert property (p_cmd_we) else $error("write enable low in command");
    property p_cmd_msb; cmd_r && !o_ce_b |-> !o_addr[16]; endproperty
    a_cmd_msb: assert property (p_cmd_msb) else $error("top address bit set");
    property p_oe_nodrive; !o_oe_b |-> !o_data_pins_oe; endproperty
    a_oe_nodrive: assert property (p_oe_nodrive) else $error("host drives on read");
    property p_drive_we; o_data_pins_oe |-> !o_we_b; endproperty
    a_drive_we: assert property (p_drive_we) else $error("drive outside write");
    property p_cmd_hold; s_take(nvsram_host_pkg::OP_CMD) |=> !o_req_ready [*8]; endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("access inside sequence");
    property p_restore; $rose(i_rst_b) |-> !o_req_ready [*8]; endproperty
    a_restore: assert property (p_restore) else $error("ready before restore");
    property p_idle;
        o_rsp_valid && cmd_r |-> o_ce_b && o_oe_b && !o_data_pins_oe && $past(o_ce_b);
    endproperty
    a_idle: assert property (p_idle) else $error("pins active in busy wait");
endmodule
bind nvsram_host nvsram_host_checker nvsram_host_checker_i (.*);
